// >>> rtl/qebc_chain_if.sv
interface qebc_chain_if;
  logic                           shift_en;
  logic                           bit_in;
  logic                           clear;
  logic [qebc_pkg::CHAIN_LEN-1:0] regs;

  modport ctl   (output shift_en, output bit_in, output clear, input regs);
  modport chain (input shift_en, input bit_in, input clear, output regs);
endinterface

// >>> rtl/qebc_pkg.sv
package qebc_pkg;

  // lane and serial chain geometry
  localparam int LANES     = 4;
  localparam int BOOST_W   = 5;
  localparam int CHAIN_LEN = 21;
  localparam int OVR_IDX   = 0;
  localparam int LANE_BASE = 1;
  localparam int AMP_W     = 8;
  localparam int PIN_W     = 28;

  // register byte offsets
  localparam logic [3:0] ADDR_THRESH = 4'h0;
  localparam logic [3:0] ADDR_SREGS  = 4'h4;
  localparam logic [3:0] ADDR_LSTAT  = 4'h8;
  localparam logic [3:0] ADDR_BOOST  = 4'hc;

  // reset values
  localparam logic [AMP_W-1:0]     THRESH_RST = 8'h10;
  localparam logic [CHAIN_LEN-1:0] CHAIN_RST  = 21'h000000;
  // synchroniser reset at pin idle levels, window pin high
  localparam logic [PIN_W-1:0]     PIN_SYNC_RST = 28'h2000000;

  // lane status field positions
  localparam int LSTAT_MUTE_LSB = 0;
  localparam int LSTAT_PWR_LSB  = 4;
  localparam int LSTAT_OVR_BIT  = 8;
  localparam int LSTAT_MODE_BIT = 9;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // three-level pin digit codes
  typedef logic [1:0] qebc_digit_t;
  localparam qebc_digit_t DIGIT_LOW  = 2'h0;
  localparam qebc_digit_t DIGIT_MID  = 2'h1;
  localparam qebc_digit_t DIGIT_HIGH = 2'h2;

  // digit to 0..2, unused code reads as high
  function automatic logic [4:0] qebc_tern(qebc_digit_t d);
    logic [4:0] v;
    v = 5'h2;
    if (d == DIGIT_LOW) v = 5'h0;
    else if (d == DIGIT_MID) v = 5'h1;
    return v;
  endfunction

  // three-digit pin code to one of 18 boost levels
  function automatic logic [4:0] qebc_pin_level(logic a, qebc_digit_t b,
                                                qebc_digit_t c);
    logic [4:0] idx;
    logic [4:0] lvl;
    idx = (a ? 5'h9 : 5'h0) + 5'(3 * qebc_tern(b)) + qebc_tern(c);
    case (idx)
      5'h00:   lvl = 5'h00;
      5'h01:   lvl = 5'h02;
      5'h02:   lvl = 5'h04;
      5'h03:   lvl = 5'h06;
      5'h04:   lvl = 5'h08;
      5'h05:   lvl = 5'h0a;
      5'h06:   lvl = 5'h0c;
      5'h07:   lvl = 5'h0e;
      5'h08:   lvl = 5'h0f;
      5'h09:   lvl = 5'h10;
      5'h0a:   lvl = 5'h11;
      5'h0b:   lvl = 5'h13;
      5'h0c:   lvl = 5'h15;
      5'h0d:   lvl = 5'h17;
      5'h0e:   lvl = 5'h18;
      5'h0f:   lvl = 5'h1a;
      5'h10:   lvl = 5'h1c;
      default: lvl = 5'h1f;
    endcase
    return lvl;
  endfunction

endpackage

// >>> rtl/qebc_shift_chain.sv
module qebc_shift_chain (
  input  wire logic    aclk,
  input  wire logic    aresetn,
  input  wire logic    ce,
  qebc_chain_if.chain  cif
);

  // 21-stage chain: stage 0 takes the new bit, last stage feeds out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cif.regs <= qebc_pkg::CHAIN_RST;
    end else if (ce) begin
      if (cif.clear) begin
        cif.regs <= qebc_pkg::CHAIN_RST;
      end else if (cif.shift_en) begin
        cif.regs <= {cif.regs[qebc_pkg::CHAIN_LEN-2:0], cif.bit_in};
      end
    end
  end

endmodule

// >>> rtl/qebc_top.sv
// Contract
// - four lanes, independent boost, 32 or 18
// - mute lane when amplitude below threshold
// - muted lane idles at common mode
// - boost from external setting only, no adaptation
// - lane off or pin low: input high impedance
// - power-control pin low powers down lane alone
// - capture serial bit on serial clock rise
// - serial output is input delayed 21 clocks
// - programmed registers override the control pins
// - pin A most significant, pin C least
// - serial programming only while mode high
// - mode low clears registers, pins set boost
// - enable low for programming, else ignored
// - register 1 selects registers or pins
// - five-register lane words, lowest is LSB
// - all 21 registers zero after reset
// - pin code maps onto 18 levels
module qebc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // register bus
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // serial programming pins
  input  wire logic        serial_clk,
  input  wire logic        serial_in,
  input  wire logic        prog_window_n,
  input  wire logic        boost_mode,
  output logic             serial_out,
  // lane control pins
  input  wire logic [3:0]  lane_power_ctl,
  input  wire logic [3:0]  boost_select_a,
  input  wire logic [7:0]  boost_select_b,
  input  wire logic [7:0]  boost_select_c,
  // amplitude estimates from the lane detectors, same clock
  input  wire logic [31:0] lane_amplitude,
  // lane controls
  output logic [19:0]      boost_level,
  output logic             boost_override,
  output logic [3:0]       lane_active,
  output logic [3:0]       lane_input_hiz,
  output logic [3:0]       lane_mute,
  output logic [3:0]       lane_swing_en
);

  localparam int L  = qebc_pkg::LANES;
  localparam int BW = qebc_pkg::BOOST_W;
  localparam int CL = qebc_pkg::CHAIN_LEN;
  localparam int AW = qebc_pkg::AMP_W;
  localparam int PW = qebc_pkg::PIN_W;

  // pin synchroniser stages
  logic [PW-1:0]  pin_meta;
  logic [PW-1:0]  pin_sync;
  logic [PW-1:0]  pin_raw;
  logic           sclk_prev;
  logic           win_prev;

  // software and chain state
  logic [AW-1:0]  thresh;
  logic [CL-1:0]  shadow;

  // write channel holding state
  logic [3:0]     aw_addr_q;
  logic           aw_got;
  logic [31:0]    w_data_q;
  logic [3:0]     w_strb_q;
  logic           w_got;

  // decoded pin levels
  wire            s_sclk;
  wire            s_sin;
  wire            s_win_n;
  wire            s_mode;
  wire [3:0]      s_pwr;
  wire [3:0]      s_a;
  wire [7:0]      s_b;
  wire [7:0]      s_c;

  qebc_chain_if cif ();

  qebc_shift_chain u_chain (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .cif     (cif.chain)
  );

  // all pin inputs packed for the two-stage synchroniser
  assign pin_raw = {serial_clk, serial_in, prog_window_n, boost_mode,
                    lane_power_ctl, boost_select_a, boost_select_b,
                    boost_select_c};

  // two flip-flops before any logic looks at a pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= qebc_pkg::PIN_SYNC_RST; // no false window edge
      pin_sync <= qebc_pkg::PIN_SYNC_RST;
    end else if (ce) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // unpack synchronised pins
  assign s_sclk  = pin_sync[27];
  assign s_sin   = pin_sync[26];
  assign s_win_n = pin_sync[25];
  assign s_mode  = pin_sync[24];
  assign s_pwr   = pin_sync[23:20];
  assign s_a     = pin_sync[19:16];
  assign s_b     = pin_sync[15:8];
  assign s_c     = pin_sync[7:0];

  // edge history of the serial clock and the enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_prev <= 1'b0;
      win_prev  <= 1'b1;
    end else if (ce) begin
      sclk_prev <= s_sclk;
      win_prev  <= s_win_n;
    end
  end

  // serial port decode
  wire sclk_rise = s_sclk & ~sclk_prev;
  wire prog_open = ~s_win_n & s_mode;
  wire win_close = s_win_n & ~win_prev & s_mode;

  assign cif.shift_en = sclk_rise & prog_open;
  assign cif.bit_in   = s_sin;
  assign cif.clear    = ~s_mode;

  // shadow copy takes chain contents when the window closes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow <= qebc_pkg::CHAIN_RST;
    end else if (ce) begin
      if (!s_mode) begin
        shadow <= qebc_pkg::CHAIN_RST;
      end else if (win_close) begin
        shadow <= cif.regs;
      end
    end
  end

  // daisy-chain output from the last chain stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_out <= 1'b0;
    end else if (ce) begin
      serial_out <= cif.regs[CL-1];
    end
  end

  // per-lane boost source selection and lane state
  wire          ovr = shadow[qebc_pkg::OVR_IDX] & s_mode;
  logic [19:0]  next_boost;
  logic [3:0]   next_mute;

  genvar k;
  generate
    for (k = 0; k < L; k++) begin : g_lane
      wire [BW-1:0] pin_lvl;
      wire [BW-1:0] reg_lvl;
      wire [AW-1:0] amp;
      // A is the top digit, C the bottom one
      assign pin_lvl = qebc_pkg::qebc_pin_level(s_a[k],
                         s_b[2*k +: 2], s_c[2*k +: 2]);
      // lane word: lowest register number is the LSB
      assign reg_lvl = shadow[qebc_pkg::LANE_BASE + BW*k +: BW];
      // register word wins over the pins once override is set
      assign next_boost[BW*k +: BW] = ovr ? reg_lvl : pin_lvl;
      assign amp = lane_amplitude[AW*k +: AW];
      // quiet or powered-down lane is muted
      assign next_mute[k] = ~s_pwr[k] | (amp < thresh);
    end
  endgenerate

  // lane outputs, each from a flip-flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boost_level    <= '0;
      boost_override <= 1'b0;
      lane_active    <= '0;
      lane_input_hiz <= '1;
      lane_mute      <= '1;
      lane_swing_en  <= '0;
    end else if (ce) begin
      boost_level    <= next_boost;
      boost_override <= ovr;
      lane_active    <= s_pwr;
      lane_input_hiz <= ~s_pwr;
      lane_mute      <= next_mute;
      lane_swing_en  <= ~next_mute;
    end
  end

  // read decode
  wire         rd_hit = (araddr == qebc_pkg::ADDR_THRESH) |
                        (araddr == qebc_pkg::ADDR_SREGS) |
                        (araddr == qebc_pkg::ADDR_LSTAT) |
                        (araddr == qebc_pkg::ADDR_BOOST);
  logic [31:0] lstat_word;
  logic [31:0] rd_word;

  // lane status word
  always_comb begin
    lstat_word = '0;
    lstat_word[qebc_pkg::LSTAT_MUTE_LSB +: 4] = lane_mute;
    lstat_word[qebc_pkg::LSTAT_PWR_LSB +: 4]  = lane_active;
    lstat_word[qebc_pkg::LSTAT_OVR_BIT]       = boost_override;
    lstat_word[qebc_pkg::LSTAT_MODE_BIT]      = s_mode;
  end

  // read data selection
  always_comb begin
    case (araddr)
      qebc_pkg::ADDR_THRESH: rd_word = {24'h000000, thresh};
      qebc_pkg::ADDR_SREGS:  rd_word = {11'h000, shadow};
      qebc_pkg::ADDR_LSTAT:  rd_word = lstat_word;
      qebc_pkg::ADDR_BOOST:  rd_word = {12'h000, boost_level};
      default:               rd_word = 32'h00000000;
    endcase
  end

  // read channel: one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= qebc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_word;
        rresp   <= rd_hit ? qebc_pkg::RESP_OKAY : qebc_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // write decode on the held address
  wire wr_go     = aw_got & w_got & ~bvalid;
  wire wr_thresh = aw_addr_q == qebc_pkg::ADDR_THRESH;
  wire wr_ro     = (aw_addr_q == qebc_pkg::ADDR_SREGS) |
                   (aw_addr_q == qebc_pkg::ADDR_LSTAT) |
                   (aw_addr_q == qebc_pkg::ADDR_BOOST);

  // write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready   <= 1'b0;
        aw_got    <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready   <= 1'b0;
        w_got    <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
      end
      if (bvalid && bready) begin
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= qebc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= (wr_thresh | wr_ro) ? qebc_pkg::RESP_OKAY
                                      : qebc_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // mute threshold register, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thresh <= qebc_pkg::THRESH_RST;
    end else if (ce) begin
      if (wr_go && wr_thresh && w_strb_q[0]) begin
        thresh <= w_data_q[AW-1:0];
      end
    end
  end

endmodule

// >>> test/qebc_chk.sv
module qebc_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       prog_window_n,
  input wire logic       boost_mode,
  input wire logic       serial_out,
  input wire logic       boost_override,
  input wire logic [3:0] lane_power_ctl,
  input wire logic [3:0] lane_active,
  input wire logic [3:0] lane_input_hiz,
  input wire logic [3:0] lane_mute,
  input wire logic [3:0] lane_swing_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both halves of a write taken at one edge
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_off_hold;
    (!lane_power_ctl[2]) [*5];
  endsequence

  // write answer follows the taken pair
  a_write_answer: assert property (s_wr_take |-> ##[1:3] bvalid)
    else $error("write response missing");
  // isolation follows the power pin, swing and mute track each other
  a_hiz_power: assert property (s_off_hold |-> lane_input_hiz[2])
    else $error("isolation off with power pin low");
  a_swing_mute: assert property (lane_swing_en == ~lane_mute)
    else $error("swing not opposite of mute");
  a_off_muted: assert property ((~lane_active & ~lane_mute) == 4'h0)
    else $error("unpowered lane not muted");
  // power pins reach the lanes after synchronising
  a_lanes_on: assert property (
    (lane_power_ctl == 4'hf) [*5] |-> lane_active == 4'hf)
    else $error("powered lane inactive");
  a_lane_off: assert property (s_off_hold |-> !lane_active[2])
    else $error("lane stays on with pin low");
  // mode low drops the override
  a_mode_clear: assert property (
    (!boost_mode) [*6] |-> !boost_override)
    else $error("override kept with mode low");
  // a closed window keeps the chain still
  a_window_hold: assert property (
    (prog_window_n && boost_mode) [*8] |-> $stable(serial_out))
    else $error("chain moved with window closed");
endmodule

bind qebc_top qebc_chk qebc_chk_i (.*);

// >>> test/qebc_serial_host.sv
module qebc_serial_host (
  output logic serial_clk,
  output logic serial_in,
  output logic prog_window_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle: clock parked low, data at its pull-down level
  initial begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
    prog_window_n = 1'b1;
  end

  // one frame, register 21 first; shut keeps the window high
  // link clock slowed so the sampling clock sees each phase
  task automatic send(input logic [20:0] w, input int half, input bit shut);
    #10; // keep pin changes off the sampling edges
    prog_window_n = shut;
    #half;
    for (int i = 20; i >= 0; i--) begin
      serial_in = w[i];
      #half;
      serial_clk = 1'b1;
      #half;
      serial_clk = 1'b0;
    end
    serial_in = 1'b0;
    #half;
    prog_window_n = 1'b1;
  endtask
endmodule

// >>> test/qebc_tb_top.sv
module qebc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0, boost_mode = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, ce = 1'b1;
  logic [31:0] wdata = 32'h0, lane_amplitude = 32'hffffffff;
  logic [3:0]  lane_power_ctl = 4'hf, boost_select_a = 4'h0;
  logic [7:0]  boost_select_b = 8'h00, boost_select_c = 8'h00;
  logic        awready, wready, bvalid, arready, rvalid, boost_override;
  logic        serial_clk, serial_in, prog_window_n, serial_out;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [19:0] boost_level;
  logic [3:0]  lane_active, lane_input_hiz, lane_mute, lane_swing_en;
  logic [20:0] w;
  int          fails = 0, check_count = 0, cyc = 0;
  localparam logic [4:0] LV [18] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08,
    5'h0a, 5'h0c, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h13, 5'h15, 5'h17, 5'h18,
    5'h1a, 5'h1c, 5'h1f};

  qebc_top qebc_top_i (.*);
  qebc_serial_host qebc_serial_host_i (.*);

  always #20 aclk = ~aclk;

  // comparison, counting and reporting
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // bus write: both halves offered, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  // lanes 0 and 2 get code p, lanes 1 and 3 code q
  task automatic pins(input int p, input int q);
    logic [3:0] a;
    logic [7:0] b, c;
    int n;
    for (int k = 0; k < 4; k++) begin
      n = k[0] ? q : p;
      a[k] = 1'(n / 9);
      b[2*k +: 2] = 2'((n / 3) % 3);
      c[2*k +: 2] = 2'(n % 3);
    end
    @(posedge aclk);
    boost_select_a <= a;
    boost_select_b <= b;
    boost_select_c <= c;
    repeat (5) @(posedge aclk);
    chk("pins", {LV[q], LV[p], LV[q], LV[p]}, boost_level);
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_sim;
    end
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // reset state, read-only and unmapped places
    rd(qebc_pkg::ADDR_THRESH);
    chk("thresh", qebc_pkg::THRESH_RST, d);
    rd(qebc_pkg::ADDR_SREGS);
    chk("sregs", 32'h0, d);
    wr(qebc_pkg::ADDR_SREGS, 32'h1fffff);
    chk("ro resp", qebc_pkg::RESP_OKAY, r);
    rd(qebc_pkg::ADDR_SREGS);
    chk("ro kept", 32'h0, d);
    wr(4'h6, 32'h1);
    chk("unmapped wr", qebc_pkg::RESP_SLVERR, r);
    rd(4'h6);
    chk("unmapped", qebc_pkg::RESP_SLVERR, r);
    $display("test registers done");
    // mode grounded: every pin code on mirrored lanes
    for (int i = 0; i < 18; i++) pins(i, 17 - i);
    // unused digit code 11 reads as high
    boost_select_a <= 4'hf;
    boost_select_b <= 8'hff;
    boost_select_c <= 8'hff;
    repeat (5) @(posedge aclk);
    chk("code 11", {4{LV[17]}}, boost_level);
    chk("ovr", 32'h0, boost_override);
    $display("test pins done");
    // program, daisy output, second frame, closed window
    boost_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    w = {5'h1b, 5'h10, 5'h01, 5'h1f, 1'b1};
    qebc_serial_host_i.send(w, 160, 1'b0);
    repeat (6) @(posedge aclk);
    chk("boost", {1'b1, w[20:1]}, {boost_override, boost_level});
    chk("daisy", w[20], serial_out);
    rd(qebc_pkg::ADDR_SREGS);
    chk("sregs", w, d);
    w = {5'h00, 5'h0a, 5'h15, 5'h03, 1'b1};
    qebc_serial_host_i.send(w, 160, 1'b0);
    repeat (6) @(posedge aclk);
    chk("second", w[20:1], boost_level);
    chk("daisy", w[20], serial_out);
    qebc_serial_host_i.send(21'h1ffffe, 160, 1'b1);
    repeat (6) @(posedge aclk);
    chk("shut", w[20:1], boost_level);
    chk("shut daisy", w[20], serial_out);
    $display("test serial done");
    // mode low clears and refuses programming
    boost_mode <= 1'b0;
    pins(17, 0);
    chk("clr ovr", 32'h0, boost_override);
    qebc_serial_host_i.send(w, 160, 1'b0);
    boost_mode <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(qebc_pkg::ADDR_SREGS);
    chk("no prog", 32'h0, d);
    $display("test mode done");
    // threshold muting and per-lane power
    wr(qebc_pkg::ADDR_THRESH, 32'h40);
    lane_amplitude <= 32'h00803f40;
    lane_power_ctl <= 4'hb;
    repeat (5) @(posedge aclk);
    chk("mute", 4'he, lane_mute);
    chk("active", 4'hb, lane_active);
    chk("hiz", 4'h4, lane_input_hiz);
    rd(qebc_pkg::ADDR_LSTAT);
    chk("lstat", 32'h2be, d);
    lane_amplitude <= 32'h00804140;
    repeat (3) @(posedge aclk);
    chk("swing", 4'h3, lane_swing_en);
    chk("steady", {LV[0], LV[17], LV[0], LV[17]}, boost_level);
    $display("test lanes done");
    // clock enable low freezes the lane state
    ce <= 1'b0;
    lane_amplitude <= 32'h00000000;
    repeat (4) @(posedge aclk);
    chk("freeze", 4'hc, lane_mute);
    ce <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("thaw", 4'hf, lane_mute);
    $display("test enable done");
    end_sim;
  end
endmodule
